/* File: logic/crs_core_regs.sv */
`timescale 1ns/10ps
`default_nettype none
`include "crs_map.svh"
module crs_core_regs #(
	parameter int ICR_COUNT = `CRS_ICR_COUNT,
	parameter int BR_TAKEN_CYC = `CRS_BR_TAKEN_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Reset vector fetch
	output logic vec_req,
	output logic [16:0] vec_addr,
	input wire logic vec_ack,
	input wire logic [15:0] vec_data,
	// Register write port and flag update
	input wire logic wr_en,
	input wire crs_pkg::crs_wsel_type wr_sel,
	input wire logic [15:0] wr_data,
	input wire crs_pkg::crs_flag_upd_type flag_upd,
	// Interrupt entry and return
	input wire logic irq_req,
	input wire logic [1:0] irq_level,
	input wire logic nmi_req,
	input wire logic reti_req,
	input wire logic [7:0] pop_data,
	output logic irq_accept,
	output logic irq_is_nmi,
	output logic push_valid,
	output logic [7:0] push_data,
	output logic [15:0] push_addr,
	// Program counter and pipeline
	input wire logic pc_load,
	input wire logic [20:0] pc_load_val,
	input wire logic pc_step_en,
	input wire logic [4:0] pc_step,
	input wire logic branch_req,
	input wire logic branch_taken,
	input wire logic instr_mem,
	output logic busy,
	output logic [3:0] pipe_stage,
	// Data address generation
	input wire logic data_req,
	input wire logic data_store,
	input wire logic [15:0] data_off,
	output logic data_addr_valid,
	output logic [16:0] data_addr,
	// Control register access
	input wire crs_pkg::crs_sfr_req_type sfr,
	output logic sfr_ack,
	output logic [7:0] sfr_rdata,
	// Register contents
	output logic [7:0] data_reg_0,
	output logic [7:0] data_reg_1,
	output logic [7:0] data_reg_2,
	output logic [7:0] data_reg_3,
	output logic [15:0] data_word_pair_lo,
	output logic [15:0] data_word_pair_hi,
	output logic [15:0] addr_ptr_0,
	output logic [15:0] addr_ptr_1,
	output logic [15:0] stack_pointer,
	output logic [20:0] program_counter,
	output logic [7:0] processor_status_word
);
	import crs_pkg::*;

	// ****************************************
	// Reset vector sequencer
	// ****************************************
	crs_vec_state_type vec_state_r, vec_state_nxt; // Sequencer state
	logic running; // Core may execute
	assign running = (vec_state_r == CRS_RUN);

	// Ask once for the vector, then run; nothing executes before it lands
	always_comb
	begin
		vec_state_nxt = vec_state_r;
		case (vec_state_r)
			CRS_VEC_REQ: vec_state_nxt = CRS_VEC_WAIT;
			CRS_VEC_WAIT: if (vec_ack) vec_state_nxt = CRS_RUN; // RULE_06
			CRS_RUN: vec_state_nxt = CRS_RUN;
			default: vec_state_nxt = CRS_VEC_REQ;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			vec_state_r <= CRS_VEC_REQ;
		else
			vec_state_r <= vec_state_nxt;
	end

	// ****************************************
	// Data registers
	// ****************************************
	logic [3:0][7:0] data_r, data_nxt; // Four byte registers
	logic [3:0] d_we; // Byte write strobes
	logic [3:0][7:0] d_wdata; // Byte lanes of write data
	logic wr_ok; // Writes only once running

	assign wr_ok = wr_en && running;

	// Byte writes hit one register, word writes hit a pair, low byte first
	always_comb
	begin
		d_we = 4'h0;
		d_wdata = {4{wr_data[7:0]}};
		case (wr_sel)
			CRS_SEL_D0: d_we = 4'h1; // RULE_01
			CRS_SEL_D1: d_we = 4'h2;
			CRS_SEL_D2: d_we = 4'h4;
			CRS_SEL_D3: d_we = 4'h8;
			CRS_SEL_DW0:
			begin
				d_we = 4'h3; // RULE_02
				d_wdata = {wr_data, wr_data};
			end
			CRS_SEL_DW1:
			begin
				d_we = 4'hC; // RULE_02
				d_wdata = {wr_data, wr_data};
			end
			default: d_we = 4'h0;
		endcase
		if (!wr_ok)
			d_we = 4'h0;
	end

	for (genvar i = 0; i < 4; i++)
	begin : g_data
		// Each byte takes its lane when strobed
		always_comb
		begin
			data_nxt[i] = d_we[i] ? d_wdata[i] : data_r[i];
		end

		always_ff @(posedge clk_sys or negedge resetn)
		begin
			if (!resetn)
				data_r[i] <= `CRS_DATA_RST; // RULE_03
			else
				data_r[i] <= data_nxt[i];
		end
	end

	// ****************************************
	// Pointers, stack and status word
	// ****************************************
	logic [15:0] a0_r, a0_nxt, a1_r, a1_nxt; // Address pointers
	logic [15:0] sp_r, sp_nxt; // Stack pointer
	logic [7:0] psw_r, psw_nxt; // Status word
	logic [7:0] mem_ctl_r; // Holds the enable preset
	logic irq_accept_r, irq_is_nmi_r, push_valid_r; // Entry pulses
	logic [7:0] push_data_r; // Status word saved on entry
	logic [15:0] push_addr_r; // Slot that receives it
	logic mask_ok, take, is_nmi, reti_ok; // Interrupt decisions
	logic zero_res, msb_res; // Flag terms

	// Level n passes when n is below the mask level; level 3 never passes
	assign mask_ok = psw_r[`CRS_PSW_MIE] && (irq_level != 2'b11)
		&& (irq_level < psw_r[`CRS_PSW_IM_HI:`CRS_PSW_IM_LO]); // RULE_15 RULE_21
	// Hold off one cycle after a take so a request still high is not taken twice
	assign take = running && !irq_accept_r && (nmi_req || (irq_req && mask_ok)); // RULE_15
	assign is_nmi = nmi_req;
	assign reti_ok = running && reti_req && !take;
	assign zero_res = flag_upd.word ? (flag_upd.result == 16'h0000) : (flag_upd.result[7:0] == 8'h00);
	assign msb_res = flag_upd.word ? flag_upd.result[15] : flag_upd.result[7];

	// Entry beats return beats a stack pointer or status write; a status write beats a flag update; pointer writes always land
	always_comb
	begin
		a0_nxt = a0_r;
		a1_nxt = a1_r;
		sp_nxt = sp_r;
		psw_nxt = psw_r;
		if (wr_ok && wr_sel == CRS_SEL_A0)
			a0_nxt = wr_data;
		if (wr_ok && wr_sel == CRS_SEL_A1)
			a1_nxt = wr_data;
		if (take)
		begin
			sp_nxt = sp_r - 16'h0001; // RULE_08
			psw_nxt[`CRS_PSW_BKD] = 1'b1; // RULE_22
			psw_nxt[`CRS_PSW_MIE] = mem_ctl_r[`CRS_MEM_PRESET]; // RULE_16
		end
		else if (reti_ok)
		begin
			sp_nxt = sp_r + 16'h0001;
			psw_nxt = pop_data; // RULE_08 RULE_22
		end
		else
		begin
			if (wr_ok && wr_sel == CRS_SEL_SP)
				sp_nxt = wr_data;
			if (wr_ok && wr_sel == CRS_SEL_PSW)
				psw_nxt = wr_data[7:0]; // RULE_09 RULE_10
			else if (running && flag_upd.en)
			begin
				// Flags move only here, by a write, or by the status word popped on return
				psw_nxt[`CRS_PSW_ZF] = zero_res; // RULE_11 RULE_24
				psw_nxt[`CRS_PSW_CF] = flag_upd.carry; // RULE_12
				psw_nxt[`CRS_PSW_NF] = msb_res; // RULE_13
				psw_nxt[`CRS_PSW_VF] = flag_upd.ovf; // RULE_14
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			a0_r <= `CRS_ADDR_RST; // RULE_04
			a1_r <= `CRS_ADDR_RST;
			sp_r <= `CRS_SP_RST; // RULE_05
			psw_r <= `CRS_PSW_RST; // RULE_09
			irq_accept_r <= 1'b0;
			irq_is_nmi_r <= 1'b0;
			push_valid_r <= 1'b0;
			push_data_r <= 8'h00;
			push_addr_r <= 16'h0000;
		end
		else
		begin
			a0_r <= a0_nxt;
			a1_r <= a1_nxt;
			sp_r <= sp_nxt;
			psw_r <= psw_nxt;
			irq_accept_r <= take;
			irq_is_nmi_r <= take && is_nmi;
			push_valid_r <= take;
			push_data_r <= take ? psw_r : push_data_r; // RULE_08
			push_addr_r <= take ? sp_nxt : push_addr_r;
		end
	end

	// ****************************************
	// Program counter, branch timing, pipeline
	// ****************************************
	logic [20:0] pc_r, pc_nxt; // Half-byte program counter
	logic [1:0] br_cnt_r, br_cnt_nxt; // Extra cycles of a taken branch
	logic busy_r; // Stall while a taken branch drains
	logic [3:0] pipe_r, pipe_nxt; // Fetch, decode, execute, memory
	logic br_go; // Taken branch accepted

	assign br_go = running && branch_req && branch_taken && !busy_r;

	// The vector is a byte address; the extra LSB selects the nibble
	always_comb
	begin
		pc_nxt = pc_r;
		if (vec_state_r == CRS_VEC_WAIT && vec_ack)
			pc_nxt = {4'h0, vec_data, 1'b0}; // RULE_06 RULE_07
		else if (running && pc_load)
			pc_nxt = pc_load_val;
		else if (running && pc_step_en)
			pc_nxt = pc_r + 21'(pc_step); // RULE_07
		// Untaken branches cost nothing extra; taken ones add two cycles
		if (br_go)
			br_cnt_nxt = 2'(BR_TAKEN_CYC - 1); // RULE_17
		else if (br_cnt_r != 2'h0)
			br_cnt_nxt = br_cnt_r - 2'h1;
		else
			br_cnt_nxt = 2'h0;
		// A taken branch empties fetch and decode; only memory ops fill stage 4
		pipe_nxt[0] = running && (br_cnt_nxt == 2'h0); // RULE_18
		pipe_nxt[1] = pipe_r[0] && (br_cnt_nxt == 2'h0);
		pipe_nxt[2] = pipe_r[1];
		pipe_nxt[3] = pipe_r[2] && instr_mem; // RULE_18
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			pc_r <= 21'h000000;
			br_cnt_r <= 2'h0;
			busy_r <= 1'b0;
			pipe_r <= 4'h0;
		end
		else
		begin
			pc_r <= pc_nxt;
			br_cnt_r <= br_cnt_nxt;
			busy_r <= (br_cnt_nxt != 2'h0);
			pipe_r <= pipe_nxt;
		end
	end

	// ****************************************
	// Control registers and data addresses
	// ****************************************
	logic [7:0] cpu_mode_r, clk_ctl_r, ext_calc_r, src_bank_r, dst_bank_r, nmi_ctl_r;
	logic [ICR_COUNT-1:0][7:0] icr_r; // Maskable interrupt control block
	logic [7:0] sfr_rd_nxt, sfr_rdata_r; // Read data
	logic sfr_hit, sfr_we, sfr_ack_r; // Decode and answer
	logic data_bank; // Selected bank bit
	logic data_addr_valid_r;
	logic [16:0] data_addr_r, vec_addr_r;
	logic vec_req_r;

	assign sfr_hit = sfr.req && (sfr.addr >= `CRS_SFR_LO) && (sfr.addr <= `CRS_SFR_HI); // RULE_19
	assign sfr_we = sfr_hit && sfr.wr;
	assign data_bank = data_store ? dst_bank_r[0] : src_bank_r[0];

	// Unmapped offsets inside the window read zero; write-only reads zero
	always_comb
	begin
		sfr_rd_nxt = 8'h00;
		case (sfr.addr)
			`CRS_OFF_CPU_MODE: sfr_rd_nxt = cpu_mode_r;
			`CRS_OFF_MEM_CTL: sfr_rd_nxt = mem_ctl_r;
			`CRS_OFF_CLK_CTL: sfr_rd_nxt = clk_ctl_r;
			`CRS_OFF_SRC_BANK: sfr_rd_nxt = src_bank_r;
			`CRS_OFF_DST_BANK: sfr_rd_nxt = dst_bank_r;
			`CRS_OFF_NMI_CTL: sfr_rd_nxt = nmi_ctl_r;
			default: sfr_rd_nxt = 8'h00;
		endcase
		for (int k = 0; k < ICR_COUNT; k++)
			if (sfr.addr == 17'(`CRS_OFF_ICR_BASE + k))
				sfr_rd_nxt = icr_r[k];
		if (!sfr_hit || sfr.wr)
			sfr_rd_nxt = 8'h00;
	end

	for (genvar j = 0; j < ICR_COUNT; j++)
	begin : g_icr
		always_ff @(posedge clk_sys or negedge resetn)
		begin
			if (!resetn)
				icr_r[j] <= `CRS_SFR_RST;
			else if (sfr_we && sfr.addr == 17'(`CRS_OFF_ICR_BASE + j))
				icr_r[j] <= sfr.wdata;
		end
	end

	// Fixed control registers; bank upper nibble is never stored
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			cpu_mode_r <= `CRS_SFR_RST;
			mem_ctl_r <= `CRS_SFR_RST;
			clk_ctl_r <= `CRS_SFR_RST;
			ext_calc_r <= `CRS_SFR_RST;
			src_bank_r <= `CRS_SFR_RST;
			dst_bank_r <= `CRS_SFR_RST;
			nmi_ctl_r <= `CRS_SFR_RST;
			sfr_rdata_r <= 8'h00;
			sfr_ack_r <= 1'b0;
			data_addr_r <= 17'h00000;
			data_addr_valid_r <= 1'b0;
			vec_addr_r <= `CRS_VEC_ADDR;
			vec_req_r <= 1'b0;
		end
		else
		begin
			if (sfr_we && sfr.addr == `CRS_OFF_CPU_MODE) cpu_mode_r <= sfr.wdata;
			if (sfr_we && sfr.addr == `CRS_OFF_MEM_CTL) mem_ctl_r <= sfr.wdata;
			if (sfr_we && sfr.addr == `CRS_OFF_CLK_CTL) clk_ctl_r <= sfr.wdata;
			if (sfr_we && sfr.addr == `CRS_OFF_EXT_CALC) ext_calc_r <= sfr.wdata;
			if (sfr_we && sfr.addr == `CRS_OFF_SRC_BANK) src_bank_r <= sfr.wdata & `CRS_BANK_MASK;
			if (sfr_we && sfr.addr == `CRS_OFF_DST_BANK) dst_bank_r <= sfr.wdata & `CRS_BANK_MASK;
			if (sfr_we && sfr.addr == `CRS_OFF_NMI_CTL) nmi_ctl_r <= sfr.wdata;
			sfr_rdata_r <= sfr_rd_nxt;
			sfr_ack_r <= sfr_hit;
			// Bank disable pins data to bank 0 whatever the bank registers say
			data_addr_r <= data_req ? {data_bank & !psw_r[`CRS_PSW_BKD], data_off} : data_addr_r; // RULE_20 RULE_23
			data_addr_valid_r <= data_req;
			vec_addr_r <= `CRS_VEC_ADDR;
			vec_req_r <= (vec_state_nxt == CRS_VEC_WAIT); // RULE_06
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign vec_req = vec_req_r;
	assign vec_addr = vec_addr_r;
	assign irq_accept = irq_accept_r;
	assign irq_is_nmi = irq_is_nmi_r;
	assign push_valid = push_valid_r;
	assign push_data = push_data_r;
	assign push_addr = push_addr_r;
	assign busy = busy_r;
	assign pipe_stage = pipe_r;
	assign data_addr_valid = data_addr_valid_r;
	assign data_addr = data_addr_r;
	assign sfr_ack = sfr_ack_r;
	assign sfr_rdata = sfr_rdata_r;
	assign data_reg_0 = data_r[0];
	assign data_reg_1 = data_r[1];
	assign data_reg_2 = data_r[2];
	assign data_reg_3 = data_r[3];
	assign data_word_pair_lo = {data_r[1], data_r[0]};
	assign data_word_pair_hi = {data_r[3], data_r[2]};
	assign addr_ptr_0 = a0_r;
	assign addr_ptr_1 = a1_r;
	assign stack_pointer = sp_r;
	assign program_counter = pc_r;
	assign processor_status_word = psw_r;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence s_taken_branch;
		br_go;
	endsequence
	sequence s_two_stall_then_free;
		busy_r [*2] ##1 !busy_r;
	endsequence

	property p_pre_run_values;
		!running |-> (data_r == 32'h0) && (a0_r == 16'h0) && (a1_r == 16'h0) && (sp_r == 16'h0100);
	endproperty
	a_pre_run_values: assert property (p_pre_run_values) else $error("registers not at reset values"); // RULE_03

	property p_vector_load;
		(vec_state_r == CRS_VEC_WAIT && vec_ack) |=> running && pc_r == {4'h0, $past(vec_data), 1'b0};
	endproperty
	a_vector_load: assert property (p_vector_load) else $error("vector not loaded"); // RULE_06

	property p_branch_taken;
		s_taken_branch |=> s_two_stall_then_free;
	endproperty
	a_branch_taken: assert property (p_branch_taken) else $error("taken branch timing wrong"); // RULE_17

	property p_entry_push;
		take |=> push_valid_r && push_data_r == $past(psw_r) && psw_r[7] && sp_r == $past(sp_r) - 16'h0001;
	endproperty
	a_entry_push: assert property (p_entry_push) else $error("entry push wrong"); // RULE_22

	property p_return_pop;
		reti_ok |=> psw_r == $past(pop_data) && sp_r == $past(sp_r) + 16'h0001;
	endproperty
	a_return_pop: assert property (p_return_pop) else $error("status not restored"); // RULE_08

	property p_refuse_disabled;
		(!psw_r[6] && !nmi_req) |=> !irq_accept_r;
	endproperty
	a_refuse_disabled: assert property (p_refuse_disabled) else $error("maskable taken while disabled"); // RULE_15

	property p_zero_flag;
		(running && flag_upd.en && !take && !reti_ok && !(wr_ok && wr_sel == CRS_SEL_PSW))
			|=> psw_r[0] == $past(zero_res) && psw_r[2] == $past(msb_res);
	endproperty
	a_zero_flag: assert property (p_zero_flag) else $error("zero or negative flag wrong"); // RULE_11

	property p_flags_hold;
		(!flag_upd.en && !take && !reti_ok && !wr_ok) |=> $stable(psw_r[3:0]);
	endproperty
	a_flags_hold: assert property (p_flags_hold) else $error("flags moved without cause"); // RULE_24

	property p_bank_confine;
		(data_req && psw_r[7]) |=> data_addr_valid_r && !data_addr_r[16];
	endproperty
	a_bank_confine: assert property (p_bank_confine) else $error("bank used while disabled"); // RULE_23
endmodule
`default_nettype wire

/* File: pkg/crs_map.svh */
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH
// Function
// RULE_01: Four 8-bit general data registers.
// RULE_02: Data registers pair into two 16-bit words.
// RULE_03: Reset clears every data register.
// RULE_04: Two 16-bit address pointers, reset zero.
// RULE_05: Stack pointer 16 bits, reset 0x0100.
// RULE_06: Program counter loads vector from 0x04000.
// RULE_07: Program counter 21 bits, LSB half-byte.
// RULE_08: Status word pushed on interrupt, popped on return.
// RULE_09: Bit 7 bank disable; status resets zero.
// RULE_10: Bit 6 interrupt enable; bits 5-4 mask.
// RULE_11: Zero flag bit 0 on zero result.
// RULE_12: Carry flag bit 1 on carry/borrow.
// RULE_13: Negative flag bit 2 copies MSB.
// RULE_14: Overflow flag bit 3 on signed overflow.
// RULE_15: Enable gates maskable interrupts by mask level.
// RULE_16: Interrupt entry loads enable from preset bit.
// RULE_17: Branch 1 cycle untaken, 3 taken.
// RULE_18: Fetch, decode, execute, plus memory stage.
// RULE_19: Control registers mapped in 0x03000-0x03FFF.
// RULE_20: 128 KB space, two 64 KB data banks.
// RULE_21: Three maskable levels plus non-maskable interrupt.
// RULE_22: Entry forces bank disable; return restores it.
// RULE_23: Bank disable confines data to first 64 KB.
// RULE_24: Flags change only by update or write. The code also loads them from the status word popped on return.

// ****************************************
// Register offsets
// ****************************************
`define CRS_SFR_LO 17'h03000
`define CRS_SFR_HI 17'h03FFF
`define CRS_OFF_CPU_MODE 17'h03F00
`define CRS_OFF_MEM_CTL 17'h03F01
`define CRS_OFF_CLK_CTL 17'h03F04
`define CRS_OFF_EXT_CALC 17'h03F07
`define CRS_OFF_SRC_BANK 17'h03F0A
`define CRS_OFF_DST_BANK 17'h03F0B
`define CRS_OFF_NMI_CTL 17'h03FE1
`define CRS_OFF_ICR_BASE 17'h03FE2
`define CRS_ICR_COUNT 29
`define CRS_VEC_ADDR 17'h04000

// ****************************************
// Field positions
// ****************************************
`define CRS_PSW_BKD 7
`define CRS_PSW_MIE 6
`define CRS_PSW_IM_HI 5
`define CRS_PSW_IM_LO 4
`define CRS_PSW_VF 3
`define CRS_PSW_NF 2
`define CRS_PSW_CF 1
`define CRS_PSW_ZF 0
`define CRS_MEM_PRESET 3
`define CRS_BANK_MASK 8'h0F

// ****************************************
// Reset values and timing
// ****************************************
`define CRS_DATA_RST 8'h00
`define CRS_ADDR_RST 16'h0000
`define CRS_SP_RST 16'h0100
`define CRS_PSW_RST 8'h00
`define CRS_SFR_RST 8'h00
`define CRS_BR_TAKEN_CYC 3
`define CRS_BR_UNTAKEN_CYC 1

`endif

/* File: pkg/crs_pkg.sv */
`default_nettype none
package crs_pkg;
	// Targets of the register write port
	typedef enum logic [3:0] {
		CRS_SEL_D0 = 4'h0,
		CRS_SEL_D1 = 4'h1,
		CRS_SEL_D2 = 4'h2,
		CRS_SEL_D3 = 4'h3,
		CRS_SEL_DW0 = 4'h4,
		CRS_SEL_DW1 = 4'h5,
		CRS_SEL_A0 = 4'h6,
		CRS_SEL_A1 = 4'h7,
		CRS_SEL_SP = 4'h8,
		CRS_SEL_PSW = 4'h9
	} crs_wsel_type;

	// Reset vector sequencer, Gray coded
	typedef enum logic [1:0] {
		CRS_VEC_REQ = 2'b00,
		CRS_VEC_WAIT = 2'b01,
		CRS_RUN = 2'b11
	} crs_vec_state_type;

	// Flag update from the execution unit
	typedef struct packed {
		logic en;
		logic word;
		logic [15:0] result;
		logic carry;
		logic ovf;
	} crs_flag_upd_type;

	// Control register access
	typedef struct packed {
		logic req;
		logic wr;
		logic [16:0] addr;
		logic [7:0] wdata;
	} crs_sfr_req_type;
endpackage
`default_nettype wire

/* File: verification/cpu_core_register_set_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "crs_map.svh"
module cpu_core_register_set_test;
	import crs_pkg::*;
	// ****************************************
	// Stimulus, outputs and bench model
	// ****************************************
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic vec_ack = 1'b0;
	logic [15:0] vec_data = 16'h0000;
	logic wr_en = 1'b0;
	crs_wsel_type wr_sel = CRS_SEL_D0;
	logic [15:0] wr_data = 16'h0000;
	crs_flag_upd_type flag_upd = '0;
	logic irq_req = 1'b0;
	logic [1:0] irq_level = 2'h0;
	logic nmi_req = 1'b0, reti_req = 1'b0;
	logic [7:0] pop_data = 8'h00;
	logic pc_load = 1'b0;
	logic [20:0] pc_load_val = 21'h000000;
	logic pc_step_en = 1'b0;
	logic [4:0] pc_step = 5'h00;
	logic branch_req = 1'b0, branch_taken = 1'b0, instr_mem = 1'b0, data_req = 1'b0, data_store = 1'b0;
	logic [15:0] data_off = 16'h0000;
	crs_sfr_req_type sfr = '0;
	logic vec_req, irq_accept, irq_is_nmi, push_valid, busy, data_addr_valid, sfr_ack;
	logic [16:0] vec_addr, data_addr;
	logic [7:0] push_data, sfr_rdata, data_reg_0, data_reg_1, data_reg_2, data_reg_3;
	logic [15:0] push_addr, data_word_pair_lo, data_word_pair_hi, addr_ptr_0, addr_ptr_1, stack_pointer;
	logic [3:0] pipe_stage;
	logic [20:0] program_counter;
	logic [7:0] processor_status_word;
	// Expected register contents, kept apart from the design
	logic [7:0] dm [4];
	logic [15:0] am [2];
	logic [15:0] sp_m;
	logic [7:0] psw_m;
	logic [20:0] pc_m;
	logic preset_m = 1'b0;
	logic [31:0] seed = 32'h4230;
	logic [31:0] r;
	crs_flag_upd_type fu; // One flag update, driven and modelled alike
	int fails = 0;
	int checks_done = 0;
	// Control register addresses, the last two outside the window
	logic [16:0] sfr_tab [12] = '{`CRS_OFF_CPU_MODE, `CRS_OFF_MEM_CTL, `CRS_OFF_CLK_CTL, `CRS_OFF_EXT_CALC,
		`CRS_OFF_SRC_BANK, `CRS_OFF_DST_BANK, `CRS_OFF_NMI_CTL, `CRS_OFF_ICR_BASE, `CRS_SFR_LO, `CRS_SFR_HI,
		17'h02FFF, `CRS_VEC_ADDR};

	always #5 clk_sys = ~clk_sys;

	crs_core_regs crs_core_regs_i (
		.clk_sys, .resetn, .vec_req, .vec_addr, .vec_ack, .vec_data, .wr_en, .wr_sel, .wr_data, .flag_upd,
		.irq_req, .irq_level, .nmi_req, .reti_req, .pop_data, .irq_accept, .irq_is_nmi, .push_valid, .push_data,
		.push_addr, .pc_load, .pc_load_val, .pc_step_en, .pc_step, .branch_req, .branch_taken, .instr_mem, .busy,
		.pipe_stage, .data_req, .data_store, .data_off, .data_addr_valid, .data_addr, .sfr, .sfr_ack, .sfr_rdata,
		.data_reg_0, .data_reg_1, .data_reg_2, .data_reg_3, .data_word_pair_lo, .data_word_pair_hi, .addr_ptr_0,
		.addr_ptr_1, .stack_pointer, .program_counter, .processor_status_word
	);

	// ****************************************
	// Expectations and comparisons
	// ****************************************
	// Xorshift keeps every run identical
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Flags as {overflow, negative, carry, zero} for the selected width
	function automatic logic [3:0] exp_flags(input crs_flag_upd_type f);
		logic [15:0] v;
		v = f.word ? f.result : {8'h00, f.result[7:0]};
		return {f.ovf, f.word ? v[15] : v[7], f.carry, v == 16'h0000};
	endfunction

	// Level 3 can never pass, as no mask level lies above it
	function automatic logic acc_exp(input logic [7:0] w, input logic [1:0] lvl);
		return w[`CRS_PSW_MIE] && lvl < w[`CRS_PSW_IM_HI:`CRS_PSW_IM_LO];
	endfunction

	task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		chk(what, {20'h00000, exp}, {20'h00000, got});
	endtask

	// Whole register set against the model
	task automatic chk_regs();
		chk("data_reg_0", dm[0], data_reg_0);
		chk("data_reg_1", dm[1], data_reg_1);
		chk("data_reg_2", dm[2], data_reg_2);
		chk("data_reg_3", dm[3], data_reg_3);
		chk("data_word_pair_lo", {dm[1], dm[0]}, data_word_pair_lo);
		chk("data_word_pair_hi", {dm[3], dm[2]}, data_word_pair_hi);
		chk("addr_ptr_0", am[0], addr_ptr_0);
		chk("addr_ptr_1", am[1], addr_ptr_1);
		chk("stack_pointer", sp_m, stack_pointer);
		chk("program_counter", pc_m, program_counter);
		chk("processor_status_word", psw_m, processor_status_word);
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ****************************************
	// Drivers
	// ****************************************
	// Reset, then vector fetch; a write offered meanwhile must be dropped
	task automatic start_up();
		int n;
		logic [31:0] v;
		@(posedge clk_sys);
		resetn <= 1'b0;
		dm = '{default: `CRS_DATA_RST};
		am = '{default: `CRS_ADDR_RST};
		sp_m = `CRS_SP_RST;
		psw_m = `CRS_PSW_RST;
		pc_m = 21'h000000;
		v = rnd();
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		wr_en <= 1'b1;
		wr_sel <= CRS_SEL_D0;
		wr_data <= 16'h005A;
		vec_data <= v[15:0];
		chk_regs();
		chk("vec_addr", `CRS_VEC_ADDR, vec_addr);
		for (n = 0; n < 16 && vec_req !== 1'b1; n++)
			@(negedge clk_sys);
		if (vec_req !== 1'b1)
		begin
			fails++;
			final_report();
		end
		@(posedge clk_sys);
		vec_ack <= 1'b1;
		wr_en <= 1'b0;
		@(posedge clk_sys);
		vec_ack <= 1'b0;
		pc_m = {4'h0, v[15:0], 1'b0};
		@(negedge clk_sys);
		chk_bit("vec_req", 1'b0, vec_req);
		chk_regs();
	endtask

	task automatic wr(input crs_wsel_type s, input logic [15:0] d);
		@(posedge clk_sys);
		wr_en <= 1'b1;
		wr_sel <= s;
		wr_data <= d;
		@(posedge clk_sys);
		wr_en <= 1'b0;
		case (s)
			CRS_SEL_DW0: {dm[1], dm[0]} = d;
			CRS_SEL_DW1: {dm[3], dm[2]} = d;
			CRS_SEL_A0: am[0] = d;
			CRS_SEL_A1: am[1] = d;
			CRS_SEL_SP: sp_m = d;
			CRS_SEL_PSW: psw_m = d[7:0];
			default: dm[s[1:0]] = d[7:0];
		endcase
		@(negedge clk_sys);
	endtask

	task automatic sfr_op(input logic w, input logic [16:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		sfr <= '{req: 1'b1, wr: w, addr: a, wdata: d};
		@(posedge clk_sys);
		sfr.req <= 1'b0;
		@(negedge clk_sys);
	endtask

	// One request for one cycle; on acceptance the status word comes back by return
	task automatic irq(input logic nmi, input logic [1:0] lvl);
		logic acc;
		logic [7:0] old;
		acc = nmi || acc_exp(psw_m, lvl);
		old = psw_m;
		@(posedge clk_sys);
		nmi_req <= nmi;
		irq_req <= ~nmi;
		irq_level <= lvl;
		@(posedge clk_sys);
		nmi_req <= 1'b0;
		irq_req <= 1'b0;
		@(negedge clk_sys);
		chk_bit("irq_accept", acc, irq_accept);
		if (acc)
		begin
			sp_m = sp_m - 16'h0001;
			psw_m[`CRS_PSW_BKD] = 1'b1;
			psw_m[`CRS_PSW_MIE] = preset_m;
			chk_bit("irq_is_nmi", nmi, irq_is_nmi);
			chk_bit("push_valid", 1'b1, push_valid);
			chk("push_data", old, push_data);
			chk("push_addr", sp_m, push_addr);
			chk_bit("bank_disable", 1'b1, processor_status_word[`CRS_PSW_BKD]);
			chk_bit("maskable_irq_enable", preset_m, processor_status_word[`CRS_PSW_MIE]);
			@(posedge clk_sys);
			reti_req <= 1'b1;
			pop_data <= old;
			@(posedge clk_sys);
			reti_req <= 1'b0;
			sp_m = sp_m + 16'h0001;
			psw_m = old;
			@(negedge clk_sys);
		end
		chk_regs();
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		start_up();
		// Control window: ack only inside it, registers reset clear
		foreach (sfr_tab[i])
		begin
			sfr_op(1'b0, sfr_tab[i], 8'h00);
			chk_bit("sfr_ack", sfr_tab[i] <= `CRS_SFR_HI && sfr_tab[i] >= `CRS_SFR_LO, sfr_ack);
			if (sfr_ack === 1'b1)
				chk("sfr_rdata", `CRS_SFR_RST, sfr_rdata);
		end
		// Write-only register reads back zero
		sfr_op(1'b1, `CRS_OFF_EXT_CALC, 8'hFF);
		sfr_op(1'b0, `CRS_OFF_EXT_CALC, 8'h00);
		chk("sfr_rdata", 8'h00, sfr_rdata);
		wr(CRS_SEL_DW1, 16'hFFFF);
		chk_regs();
		repeat (24)
		begin
			r = rnd();
			wr(crs_wsel_type'(r[19:16] % 4'h9), r[15:0]);
			chk_regs();
		end
		// Flag updates in both widths, zero result often; flags hold after
		repeat (24)
		begin
			r = rnd();
			@(posedge clk_sys);
			fu = '{en: 1'b1, word: r[20], result: r[21] ? {r[15:8], 8'h00} : r[15:0], carry: r[22], ovf: r[23]};
			flag_upd <= fu;
			psw_m[3:0] = exp_flags(fu);
			@(posedge clk_sys);
			flag_upd.en <= 1'b0;
			@(negedge clk_sys);
			chk("flags", psw_m[3:0], processor_status_word[3:0]);
			@(negedge clk_sys);
			chk_regs();
		end
		// Program counter load and nibble step
		r = rnd();
		@(posedge clk_sys);
		pc_load <= 1'b1;
		pc_load_val <= {1'b0, r[19:0]};
		@(posedge clk_sys);
		pc_load <= 1'b0;
		pc_step_en <= 1'b1;
		pc_step <= r[24:20];
		@(posedge clk_sys);
		pc_step_en <= 1'b0;
		pc_m = {1'b0, r[19:0]} + 21'(r[24:20]);
		@(negedge clk_sys);
		chk_regs();
		// Every enable, mask level and request level, then non-maskable
		wr(CRS_SEL_SP, 16'h0200);
		for (int k = 0; k < 36; k++)
		begin
			r = rnd();
			preset_m = r[8];
			sfr_op(1'b1, `CRS_OFF_MEM_CTL, 8'(preset_m) << `CRS_MEM_PRESET);
			sfr_op(1'b0, `CRS_OFF_MEM_CTL, 8'h00);
			chk("memory_control", 8'(preset_m) << `CRS_MEM_PRESET, sfr_rdata);
			wr(CRS_SEL_PSW, {8'h00, r[7], k[0], k[2:1], r[3:0]});
			irq(k >= 32, k[4:3]);
		end
		// Bank selection against bank disable and direction
		sfr_op(1'b1, `CRS_OFF_SRC_BANK, 8'hFF);
		sfr_op(1'b0, `CRS_OFF_SRC_BANK, 8'h00);
		chk("source_bank_select", `CRS_BANK_MASK, sfr_rdata);
		sfr_op(1'b1, `CRS_OFF_DST_BANK, 8'h00);
		for (int k = 0; k < 4; k++)
		begin
			r = rnd();
			wr(CRS_SEL_PSW, {8'h00, k[0], 7'h00});
			@(posedge clk_sys);
			data_req <= 1'b1;
			data_store <= k[1];
			data_off <= r[15:0];
			@(posedge clk_sys);
			data_req <= 1'b0;
			@(negedge clk_sys);
			chk_bit("data_addr_valid", 1'b1, data_addr_valid);
			chk("data_addr", {~k[1] & ~k[0], r[15:0]}, data_addr);
		end
		// Untaken then taken branch; stall only for the taken one
		for (int t = 0; t < 2; t++)
		begin
			r = rnd();
			@(posedge clk_sys);
			branch_req <= 1'b1;
			branch_taken <= t[0];
			instr_mem <= r[0];
			@(posedge clk_sys);
			branch_req <= 1'b0;
			for (int c = 1; c <= `CRS_BR_TAKEN_CYC; c++)
			begin
				@(negedge clk_sys);
				chk_bit("busy", t == 1 && c < `CRS_BR_TAKEN_CYC, busy);
			end
			chk_bit("fetch stage", 1'b1, pipe_stage[0]);
			chk_bit("memory stage", t == 0 && r[0], pipe_stage[3]);
		end
		// Second reset in mid-run with registers loaded
		wr(CRS_SEL_A1, 16'hA5C3);
		start_up();
		final_report();
	end
endmodule
`default_nettype wire
